// ---- hdl/pmrc_pkg.sv ----
// Behaviour
// - Writing reset bit resets state machines immediately
// - Reset bit self-clears when reset completes
// - Software reset acts on pages six, eighteen
// - Codes 000/001 select RGMII/SGMII to copper
// - Codes 010/011/100 select fiber or SGMII media
// - New path selection applies only at reset
// - Path field resets to 111 or 000
package pmrc_pkg;
  localparam logic [7:0] PMRC_OFF_CTRL = 8'h14;
  localparam logic [7:0] PMRC_OFF_STAT = 8'h18;
  localparam int PMRC_RST_BIT = 15;
  localparam int PMRC_MODE_HI = 2;
  localparam logic [15:0] PMRC_CTRL_RESET = 16'h0200;
  localparam logic [15:0] PMRC_CTRL_WMASK = 16'h7ffb;
  localparam int PMRC_RST_NS = 100;
  localparam int PMRC_CLK_NS = 20;
  localparam int PMRC_RST_CYC = (PMRC_RST_NS + PMRC_CLK_NS - 1) / PMRC_CLK_NS;
  localparam logic [3:0] PMRC_RST_CNT = 4'(PMRC_RST_CYC);
  localparam logic [2:0] PMRC_MODE_UNCONF = 3'h7;
  localparam logic [2:0] PMRC_MODE_RGMII_CU = 3'h0;
  typedef enum logic [2:0] {
    PMRC_PATH_RGMII_CU, PMRC_PATH_SGMII_CU, PMRC_PATH_RGMII_1000X,
    PMRC_PATH_RGMII_100FX, PMRC_PATH_RGMII_SGMII, PMRC_PATH_NONE
  } pmrc_path_e;
endpackage

// ---- hdl/pmrc_rst_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Carries the reset request and the sequencer answer
interface pmrc_rst_if;
  logic start;
  logic busy;
  logic pulse;
  modport ctrl (output start, input busy, input pulse);
  modport seq (input start, output busy, output pulse);
endinterface // pmrc_rst_if
`default_nettype wire

// ---- hdl/pmrc_rst_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
// Holds the soft reset for a fixed number of cycles
module pmrc_rst_seq (
  input wire logic clock,
  input wire logic rst_n,
  pmrc_rst_if.seq rif
);
  logic [3:0] cnt_reg;
  // Counter loads on start only when zero (a start while busy is ignored); busy while non-zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
    end else if (rif.start && cnt_reg == 4'h0) begin
      cnt_reg <= pmrc_pkg::PMRC_RST_CNT;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  assign rif.busy = (cnt_reg != 4'h0);
  assign rif.pulse = rif.busy;
endmodule // pmrc_rst_seq
`default_nettype wire

// ---- hdl/pmrc_top.sv ----
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pmrc_top #(
  parameter logic [2:0] MODE_RESET = 3'h7 // 111 or 000 depending on variant
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic soft_reset,
  output logic [2:0] path_mode,
  output logic path_valid,
  output logic pages_reset
);
  pmrc_rst_if rif ();
  logic [15:0] ctrl_reg;
  logic [2:0] mode_act_reg;
  logic busy_d_reg;
  logic [31:0] prdata_next;
  logic wr_ctrl;
  logic acc;
  logic done;

  pmrc_rst_seq u_seq (
    .clock(clock),
    .rst_n(rst_n),
    .rif(rif)
  );

  // Decode a mode code to an operating path
  function automatic pmrc_pkg::pmrc_path_e decode_path(input logic [2:0] m);
    unique case (m)
      3'h0: decode_path = pmrc_pkg::PMRC_PATH_RGMII_CU;
      3'h1: decode_path = pmrc_pkg::PMRC_PATH_SGMII_CU;
      3'h2: decode_path = pmrc_pkg::PMRC_PATH_RGMII_1000X;
      3'h3: decode_path = pmrc_pkg::PMRC_PATH_RGMII_100FX;
      3'h4: decode_path = pmrc_pkg::PMRC_PATH_RGMII_SGMII;
      default: decode_path = pmrc_pkg::PMRC_PATH_NONE;
    endcase
  endfunction

  // Zero wait-state slave; unmapped addresses answer with an error
  assign acc = psel && penable;
  assign pready = 1'b1;
  assign pslverr = acc && paddr != pmrc_pkg::PMRC_OFF_CTRL
                   && paddr != pmrc_pkg::PMRC_OFF_STAT;
  assign wr_ctrl = acc && pwrite && paddr == pmrc_pkg::PMRC_OFF_CTRL;
  assign rif.start = wr_ctrl && pwdata[pmrc_pkg::PMRC_RST_BIT];
  assign done = busy_d_reg && !rif.busy;

  // Control register; reserved bits stored as written, software keeps them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= pmrc_pkg::PMRC_CTRL_RESET;
      ctrl_reg[pmrc_pkg::PMRC_MODE_HI:0] <= MODE_RESET;
    end else begin
      if (wr_ctrl) begin
        // Reserved bits are stored as written; keeping them fixed is up to software
        ctrl_reg[pmrc_pkg::PMRC_RST_BIT-1:0] <= pwdata[pmrc_pkg::PMRC_RST_BIT-1:0];
      end
      if (rif.start) begin
        ctrl_reg[pmrc_pkg::PMRC_RST_BIT] <= 1'b1;
      end else if (done) begin
        ctrl_reg[pmrc_pkg::PMRC_RST_BIT] <= 1'b0;
      end
    end
  end

  // Active path only moves when the soft reset runs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_act_reg <= MODE_RESET;
      busy_d_reg <= 1'b0;
    end else begin
      busy_d_reg <= rif.busy;
      if (rif.start) begin
        mode_act_reg <= wr_ctrl ? pwdata[pmrc_pkg::PMRC_MODE_HI:0]
                                : ctrl_reg[pmrc_pkg::PMRC_MODE_HI:0];
      end
    end
  end

  // Read mux; status shows active mode and busy
  always_comb begin
    prdata_next = 32'h0;
    if (paddr == pmrc_pkg::PMRC_OFF_CTRL) begin
      prdata_next = {16'h0, ctrl_reg};
    end else if (paddr == pmrc_pkg::PMRC_OFF_STAT) begin
      prdata_next = {27'h0, rif.busy, path_valid, mode_act_reg};
    end
  end
  assign prdata = prdata_next;

  // Soft reset held while sequencer runs; clears pages 6 and 18 too
  assign soft_reset = rif.busy || rif.start;
  assign pages_reset = soft_reset;
  assign path_mode = mode_act_reg;
  assign path_valid = decode_path(mode_act_reg) != pmrc_pkg::PMRC_PATH_NONE;

  a_rst_start: assert property (@(posedge clock) disable iff (!rst_n)
    rif.start |-> soft_reset) else $error("soft reset not immediate");
  a_rst_clear: assert property (@(posedge clock) disable iff (!rst_n)
    rif.start |-> ##[1:8] !ctrl_reg[pmrc_pkg::PMRC_RST_BIT]) else $error("reset bit stuck");
  a_pages_rst: assert property (@(posedge clock) disable iff (!rst_n)
    pages_reset == soft_reset) else $error("pages not reset");
  a_mode_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(rif.start) |-> $stable(mode_act_reg)) else $error("mode moved");
  a_mode_take: assert property (@(posedge clock) disable iff (!rst_n)
    rif.start |=> mode_act_reg == $past(pwdata[pmrc_pkg::PMRC_MODE_HI:0]))
    else $error("mode not taken");
  a_path_cu: assert property (@(posedge clock) disable iff (!rst_n)
    mode_act_reg <= 3'h4 |-> path_valid) else $error("valid path lost");
  a_path_bad: assert property (@(posedge clock) disable iff (!rst_n)
    mode_act_reg > 3'h4 |-> !path_valid) else $error("bad path valid");
  a_bit_sc: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_reg[pmrc_pkg::PMRC_RST_BIT] |-> rif.busy || $past(rif.busy) || $past(rif.start))
    else $error("reset bit without reset");
endmodule // pmrc_top
`default_nettype wire

// ---- bench/test_pmrc.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_pmrc;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, soft_reset, path_valid, pages_reset;
  logic [2:0] path_mode;
  int n_fail = 0, n_compared = 0, cyc = 0;
  pmrc_top dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .soft_reset(soft_reset), .path_mode(path_mode),
    .path_valid(path_valid), .pages_reset(pages_reset));
  // Free-running 50 MHz clock
  initial begin
    forever #10 clock = ~clock;
  end
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; an idle edge first so psel is never reassigned in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset();
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0000_0207, "ctrl reset");
    chk({29'h0, path_mode}, 32'h7, "mode reset");
    chk({31'h0, path_valid}, 32'h0, "unconfigured");
  endtask
  // Mode written without the reset bit must not take effect
  task automatic t_hold();
    apb(1'b1, 8'h14, 32'h0000_0201);
    #1 chk({29'h0, path_mode}, 32'h7, "mode early");
    chk({31'h0, soft_reset}, 32'h0, "no reset");
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0000_0007, "status idle");
  endtask
  task automatic t_modes();
    logic [2:0] c;
    for (int i = 0; i < 6; i++) begin
      c = (i < 5) ? 3'(i) : 3'h7;
      apb(1'b1, 8'h14, 32'h0000_8200 | {29'h0, c});
      #1 chk({30'h0, soft_reset, pages_reset}, 32'h3, "reset now");
      chk({29'h0, path_mode}, {29'h0, c}, "mode applied");
      chk({31'h0, path_valid}, {31'h0, (i < 5)}, "valid");
      rd = 32'h8000;
      for (int k = 0; k < 20 && rd[15] !== 1'b0; k++) apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, rd[15]}, 32'h0, "self clear");
      chk({31'h0, soft_reset}, 32'h0, "reset over");
    end
  endtask
  task automatic t_bad();
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped");
  endtask
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_hold();
    t_modes();
    t_bad();
    finish_test();
  end
endmodule // test_pmrc
`default_nettype wire
